// ---- qdl_defines.svh ----
// constants of the quad dac serial load front end
//
// Behaviour
// - DAC registers follow their input registers while load strobe is low.
// - Load strobe updates all four DAC registers together, never one alone.
// - Clear low zeroes every input and DAC register without a clock edge.
// - Clear leaves the serial shift register untouched.
// - Chip select high blocks shifting; serial clock edges are ignored.
// - Chip select rising edge writes the word into the addressed input register unless the fifo is full.
// - Chip select has no effect on load strobe transfers.
// - Serial data is sampled on each rising serial clock edge while chip select is low.
// - Words arrive MSB first and shift straight into the shift register.
// - A floating serial data pin puts the device into hardware shutdown.
// - Shutdown never alters stored DAC register contents.
// - Shut-down channel outputs go high impedance instead of driving.
// - Word is 12 bits: all-flag, addressed-flag, two select bits, eight data.
// - Select 00, 01, 10, 11 picks channel A, B, C, D.
// - All-flag low shuts every channel; addressed-flag low shuts addressed one.
// - Only the last twelve bits shifted are used, even when they come from more than one frame.
`ifndef QDL_DEFINES_SVH
`define QDL_DEFINES_SVH

`define QDL_WORD_W 12
`define QDL_CODE_W 8
`define QDL_SEL_W 2
`define QDL_CHANNELS 4
`define QDL_FIFO_DEPTH 8

`define QDL_BIT_EVERY 11
`define QDL_BIT_ADDRESSED 10
`define QDL_BIT_SEL_HI 9
`define QDL_BIT_SEL_LO 8
`define QDL_CODE_MSB 7

`define QDL_CODE_RST 8'h00
`define QDL_SR_RST 12'h000
`define QDL_PD_RST 1'b0

`endif

// ---- qdl_fifo.sv ----
// word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module qdl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // fill and drain sides
  qdl_word_if.dst in_if,
  qdl_word_if.src out_if
);
  localparam int AW = $clog2(DEPTH);
  localparam bit [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire logic push = in_if.valid & in_if.ready;
  wire logic pop = out_if.valid & out_if.ready;

  assign in_if.ready = (count_r != FULL_CNT);
  assign out_if.valid = (count_r != '0);
  assign out_if.data = mem_r[rd_ptr_r];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_if.data;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // qdl_fifo

`default_nettype wire

// ---- qdl_host_model.sv ----
// serial master model driving the dac control link
`timescale 1ns/1ps
`default_nettype none

module qdl_host_model (
  // link pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  output logic float_sense_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
    float_sense_o = 1'b0;
  end

  // low n bits of w, msb first; sel low keeps select high
  task automatic frame(input logic [15:0] w, input int n, input logic sel);
    cs_n_o = !sel;
    #3;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      #3 sclk_o = 1'b1;
      #3 sclk_o = 1'b0;
    end
    cs_n_o = 1'b1;
    sdi_o = !sdi_o;
  endtask

  // released pin shows the inverse of its old value, never the old value
  task automatic float_pin(input logic on);
    float_sense_o = on;
    sdi_o = !sdi_o;
  endtask
endmodule // qdl_host_model

`default_nettype wire

// ---- qdl_pkg.sv ----
// types of the quad dac serial load front end
`include "qdl_defines.svh"

package qdl_pkg;

  typedef enum logic [`QDL_SEL_W-1:0] {
    QDL_CH_A,
    QDL_CH_B,
    QDL_CH_C,
    QDL_CH_D
  } qdl_chan_e;

  typedef struct packed {
    logic power_down_every_channel_n;
    logic power_down_addressed_channel_n;
    qdl_chan_e chan;
    logic [`QDL_CODE_W-1:0] code;
  } qdl_word_s;

endpackage

// ---- qdl_serial_dac_ctrl.sv ----
// quad dac serial load control: top level
`timescale 1ns/1ps
`default_nettype none
`include "qdl_defines.svh"

module qdl_serial_dac_ctrl (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // serial link
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_or_float_off_i,
  input wire logic float_sense_i,
  // hardware strobes
  input wire logic load_strobe_n_i,
  input wire logic zero_all_n_i,
  // dac side
  output logic [`QDL_CHANNELS*`QDL_CODE_W-1:0] dac_code_o,
  output logic [`QDL_CHANNELS-1:0] chan_drive_o,
  output logic [`QDL_CHANNELS-1:0] chan_power_down_o,
  output logic float_power_down_o,
  // link status
  output logic word_ready_o,
  output logic overrun_o
);

  // true when a select field picks channel idx
  function automatic logic chan_hit(input qdl_pkg::qdl_chan_e sel,
                                    input int idx);
    chan_hit = (sel == qdl_pkg::qdl_chan_e'(idx[`QDL_SEL_W-1:0]));
  endfunction

  // ---- link domain -------------------------------------------------------
  logic [`QDL_WORD_W-1:0] link_word;

  qdl_shifter u_shifter (
    .sclk_i(sclk_i),
    .rst_b_i(rst_b_i),
    .cs_n_i(cs_n_i),
    .sdi_i(serial_in_or_float_off_i),
    .word_o(link_word)
  );

  // ---- synchronisers into the system clock -------------------------------
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_s3_r;
  logic load_strobe_n_s1_r;
  logic load_strobe_n_s2_r;
  logic zero_s1_r;
  logic zero_s2_r;
  logic float_s1_r;
  logic float_s2_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      load_strobe_n_s1_r <= 1'b1;
      load_strobe_n_s2_r <= 1'b1;
      zero_s1_r <= 1'b1;
      zero_s2_r <= 1'b1;
      float_s1_r <= 1'b0;
      float_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= cs_n_i;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      load_strobe_n_s1_r <= load_strobe_n_i;
      load_strobe_n_s2_r <= load_strobe_n_s1_r;
      zero_s1_r <= zero_all_n_i;
      zero_s2_r <= zero_s1_r;
      float_s1_r <= float_sense_i;
      float_s2_r <= float_s1_r;
    end
  end

  // ---- word capture at the end of a frame --------------------------------
  // the shifter stops while chip select is high, so its word is static
  // by the time the synchronised rising edge is seen here
  wire logic cs_rise = cs_s2_r & ~cs_s3_r;

  qdl_word_if fill_if ();
  qdl_word_if drain_if ();

  assign fill_if.valid = cs_rise;
  assign fill_if.data = link_word;

  qdl_fifo #(
    .WIDTH(`QDL_WORD_W),
    .DEPTH(`QDL_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .in_if(fill_if),
    .out_if(drain_if)
  );

  logic word_ready_r;
  logic overrun_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_ready_r <= 1'b0;
      overrun_r <= 1'b0;
    end else begin
      word_ready_r <= fill_if.ready;
      // sticky: a word lost to a full fifo
      if (cs_rise && !fill_if.ready) begin
        overrun_r <= 1'b1;
      end
    end
  end

  // ---- drain into the channel registers ----------------------------------
  // writes wait once the synchronised clear is low; a word drained in the first two cycles of clear loses its code to the zeroing
  qdl_pkg::qdl_word_s wr_word;
  wire logic wr_en = drain_if.valid & drain_if.ready;

  assign drain_if.ready = zero_s2_r;
  assign wr_word = qdl_pkg::qdl_word_s'(drain_if.data);

  // clear zeroes the data registers asynchronously
  // release waits for the synchronised level, so recovery is clocked
  wire logic data_clr_b = rst_b_i & zero_all_n_i & zero_s2_r;

  logic [`QDL_CODE_W-1:0] in_r [`QDL_CHANNELS];
  logic [`QDL_CODE_W-1:0] dac_r [`QDL_CHANNELS];
  logic [`QDL_CHANNELS-1:0] pd_r;
  logic [`QDL_CHANNELS-1:0] drive_r;
  logic float_pd_r;

  for (genvar i = 0; i < `QDL_CHANNELS; i++) begin : g_ch
    wire logic hit = chan_hit(wr_word.chan, i);

    always_ff @(posedge clk_i or negedge data_clr_b) begin
      if (!data_clr_b) begin
        in_r[i] <= `QDL_CODE_RST;
      end else if (wr_en && hit) begin
        in_r[i] <= wr_word.code;
      end
    end

    // transparent while load strobe low, all channels at once
    // chip select plays no part here
    always_ff @(posedge clk_i or negedge data_clr_b) begin
      if (!data_clr_b) begin
        dac_r[i] <= `QDL_CODE_RST;
      end else if (!load_strobe_n_s2_r) begin
        dac_r[i] <= in_r[i];
      end
    end

    // power state is kept apart from the codes, which it never touches
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        pd_r[i] <= `QDL_PD_RST;
      end else if (wr_en && !wr_word.power_down_every_channel_n) begin
        pd_r[i] <= 1'b1;
      end else if (wr_en && hit) begin
        pd_r[i] <= ~wr_word.power_down_addressed_channel_n;
      end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        drive_r[i] <= 1'b1;
      end else begin
        drive_r[i] <= ~(pd_r[i] | float_s2_r);
      end
    end

    assign dac_code_o[i*`QDL_CODE_W +: `QDL_CODE_W] = dac_r[i];
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      float_pd_r <= 1'b0;
    end else begin
      float_pd_r <= float_s2_r;
    end
  end

  assign chan_drive_o = drive_r;
  assign chan_power_down_o = pd_r;
  assign float_power_down_o = float_pd_r;
  assign word_ready_o = word_ready_r;
  assign overrun_o = overrun_r;

endmodule // qdl_serial_dac_ctrl

`default_nettype wire

// ---- qdl_serial_dac_ctrl_checker.sv ----
// port assertions of the quad dac serial load control
`timescale 1ns/1ps
`default_nettype none

module qdl_serial_dac_ctrl_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic float_sense_i,
  input wire logic load_strobe_n_i,
  input wire logic zero_all_n_i,
  input wire logic [31:0] dac_code_o,
  input wire logic [3:0] chan_drive_o,
  input wire logic [3:0] chan_power_down_o,
  input wire logic float_power_down_o,
  input wire logic word_ready_o,
  input wire logic overrun_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence quiet_s;
    (load_strobe_n_i && zero_all_n_i) [*6];
  endsequence
  sequence float_s;
    float_sense_i [*6];
  endsequence
  a_clear_zero_code: assert property (!zero_all_n_i |-> dac_code_o == 32'h0)
    else $error("code not zero under clear");
  a_hold_no_load: assert property (quiet_s |-> $stable(dac_code_o))
    else $error("code moved without load");
  a_float_flag: assert property (float_s |-> float_power_down_o)
    else $error("float shutdown missing");
  a_float_no_drive: assert property (float_s |-> chan_drive_o == 4'h0)
    else $error("channel driven while floating");
  a_down_no_drive: assert property ((chan_power_down_o
    & $past(chan_power_down_o) & chan_drive_o) == 4'h0)
    else $error("shut channel still driven");
  a_overrun_sticky: assert property (overrun_o |=> overrun_o)
    else $error("overrun flag dropped");
  a_overrun_when_full: assert property ($rose(overrun_o) |-> !$past(word_ready_o))
    else $error("overrun while fifo had room");
  a_clear_keeps_down: assert property (!zero_all_n_i [*3] |=> $stable(chan_power_down_o))
    else $error("clear changed shutdown state");
endmodule // qdl_serial_dac_ctrl_checker

bind qdl_serial_dac_ctrl qdl_serial_dac_ctrl_checker qdl_serial_dac_ctrl_checker_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .float_sense_i(float_sense_i),
  .load_strobe_n_i(load_strobe_n_i), .zero_all_n_i(zero_all_n_i),
  .dac_code_o(dac_code_o), .chan_drive_o(chan_drive_o),
  .chan_power_down_o(chan_power_down_o), .float_power_down_o(float_power_down_o),
  .word_ready_o(word_ready_o), .overrun_o(overrun_o));

`default_nettype wire

// ---- qdl_shifter.sv ----
// serial shift register on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "qdl_defines.svh"

module qdl_shifter (
  // link clock and reset
  input wire logic sclk_i,
  input wire logic rst_b_i,
  // link pins
  input wire logic cs_n_i,
  input wire logic sdi_i,
  // shifted word
  output logic [`QDL_WORD_W-1:0] word_o
);
  // clear is not wired here, so it never touches this register
  always_ff @(posedge sclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      word_o <= `QDL_SR_RST;
    end else if (!cs_n_i) begin
      // msb first, older bits fall off the top
      word_o <= {word_o[`QDL_WORD_W-2:0], sdi_i};
    end
  end
endmodule // qdl_shifter

`default_nettype wire

// ---- qdl_word_if.sv ----
// valid/ready word carrier between front end modules
`timescale 1ns/1ps
`default_nettype none
`include "qdl_defines.svh"

interface qdl_word_if;
  logic valid;
  logic ready;
  logic [`QDL_WORD_W-1:0] data;

  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

`default_nettype wire

// ---- tb.sv ----
// self-checking bench for the quad dac serial load control
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ld_n = 1'b1;
  logic clr_n = 1'b1;
  wire sclk, cs_n, sdi, fsense;
  logic [31:0] dac;
  logic [3:0] drv, pd;
  logic fpd, rdy, ovr;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #4 clk_i = ~clk_i;
  qdl_host_model qdl_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n),
    .sdi_o(sdi), .float_sense_o(fsense));
  qdl_serial_dac_ctrl qdl_serial_dac_ctrl_inst (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_or_float_off_i(sdi), .float_sense_i(fsense),
    .load_strobe_n_i(ld_n), .zero_all_n_i(clr_n), .dac_code_o(dac),
    .chan_drive_o(drv), .chan_power_down_o(pd), .float_power_down_o(fpd),
    .word_ready_o(rdy), .overrun_o(ovr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic send(input logic [15:0] w, input int n);
    qdl_host_model_inst.frame(w, n, 1'b1);
    idle(10);
  endtask
  task automatic load();
    ld_n = 1'b0;
    idle(8);
    ld_n = 1'b1;
    idle(8);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    idle(20);
    rst_b_i = 1'b1;
    idle(4);
    check({28'h0, drv}, 32'hf);
    // four lead bits of junk before each word
    for (int c = 0; c < 4; c++) begin
      send({4'ha, 2'b11, c[1:0], 8'h10 + c[7:0]}, 16);
    end
    check(dac, 32'h0);
    load();
    check(dac, 32'h13121110);
    send(16'h0dc2, 12);
    qdl_host_model_inst.frame(16'h0ab3, 12, 1'b0);
    idle(4);
    send(16'h0005, 4);
    check(dac, 32'h13121110);
    load();
    check(dac, 32'h1312c225);
    send(16'h0b33, 12);
    check({28'h0, pd}, 32'h8);
    check({28'h0, drv}, 32'h7);
    clr_n = 1'b0;
    #1 check(dac, 32'h0);
    idle(4);
    clr_n = 1'b1;
    idle(4);
    send(16'h0007, 4);
    check({28'h0, pd}, 32'hf);
    check({28'h0, drv}, 32'h0);
    load();
    check(dac, 32'h37000000);
    qdl_host_model_inst.float_pin(1'b1);
    idle(10);
    check({31'h0, fpd}, 32'h1);
    check(dac, 32'h37000000);
    qdl_host_model_inst.float_pin(1'b0);
    idle(10);
    check({31'h0, fpd}, 32'h0);
    // stalled drain fills the fifo, the ninth word is dropped
    clr_n = 1'b0;
    for (int k = 0; k < 8; k++) begin
      send(16'h0c00, 12);
    end
    check({30'h0, rdy, ovr}, 32'h0);
    send(16'h0c00, 12);
    check({31'h0, ovr}, 32'h1);
    clr_n = 1'b1;
    idle(20);
    check({30'h0, rdy, ovr}, 32'h3);
    final_report();
  end
endmodule // tb

`default_nettype wire
